// File: inc/crb_pkg.sv
// Constants shared by both ends of the channel readback path
// Overview of operation
// - Host rearms interrupt: clear then set enable
// - Read address picks register, bit 0 names it
// - Read address bit 1 shows data chaining
// - Read address accepted any time, no disturbance
// - Host gaps a load before a read
// - Counter decrements per byte, interrupts at zero
// - Early end leaves remaining count
// - Chaining runs each segment to zero, reloads
// - Reads leave busy and done untouched
// - Count read stages; second read delivers
// - Load count also writes count stage
// - Status register holds address and status
// - Status read stages; second read delivers
// - Status low byte, address high byte
// - Load device address writes status register
// - Tags read stages; second read delivers
// - Some tag word bits carry channel status
// - Load output tags writes tag stage
// - First count fills counter, second next
// - Chaining moves next count into counter
// - Chaining starts on the register named by load address bit 0, alternates
package crb_pkg;
    localparam int DW = 16;
    localparam logic [3:0] FN_CLR_IRQ_EN = 4'h6;
    localparam logic [3:0] FN_SET_IRQ_EN = 4'h7;
    localparam logic [3:0] FN_RD_ADDR = 4'h8;
    localparam logic [3:0] FN_RD_COUNT = 4'h9;
    localparam logic [3:0] FN_RD_STATUS = 4'hA;
    localparam logic [3:0] FN_RD_TAGS = 4'hB;
    localparam logic [3:0] FN_LD_ADDR = 4'hC;
    localparam logic [3:0] FN_LD_COUNT = 4'hD;
    localparam logic [3:0] FN_LD_DEV = 4'hE;
    localparam logic [3:0] FN_LD_TAGS = 4'hF;
    // Read-address answer bits
    localparam int RA_SEL_BIT = 0;
    localparam int RA_CHAIN_BIT = 1;
    // Load-address parcel bits
    localparam int LA_SEL_BIT = 0;
    localparam int LA_CHAIN_BIT = 1;
    localparam int TAG_W = 12;
    // Host register byte offsets
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_RESP = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    // Host command register fields
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_TWICE_BIT = 4;
    localparam int CMD_REARM_BIT = 5;
    localparam int CMD_ACC_LSB = 16;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

// File: inc/crb_if.sv
// Function port between host processor end and channel device end
`timescale 1ns/100ps
`default_nettype none
interface crb_if;
    logic fn_valid;
    logic [3:0] fn_code;
    logic [15:0] fn_acc;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic chan_irq;
    modport dev (input fn_valid, fn_code, fn_acc, output rsp_valid, rsp_data, chan_irq);
    modport host (output fn_valid, fn_code, fn_acc, input rsp_valid, rsp_data, chan_irq);
endinterface
`default_nettype wire

// File: hw/crb_dev.sv
// Channel device end: address, count, status and tag readback
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module crb_dev
    import crb_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    crb_if.dev FN,
    input wire logic BYTE_DONE_I,
    input wire logic CU_END_I,
    input wire logic STAT_CAP_I,
    input wire logic [7:0] STAT_BYTE_I,
    input wire logic [7:0] DEV_ADDR_I,
    input wire logic [TAG_W-1:0] IN_TAGS_I,
    input wire logic CHAN_BUSY_I,
    input wire logic CHAN_DONE_I,
    output logic [15:0] OUT_TAGS_O,
    output logic [15:0] MEM_ADDR_O,
    output logic XFER_END_O
);
    // ----------------------------------------
    // Function decode
    // ----------------------------------------
    logic fv;
    logic [3:0] fc;
    logic [15:0] acc;
    assign fv = FN.fn_valid;
    assign fc = FN.fn_code;
    assign acc = FN.fn_acc;

    logic ld_addr, ld_count, ld_dev, ld_tags, rd_addr, rd_count, rd_stat, rd_tags, clr_en, set_en;
    assign ld_addr = fv && fc == FN_LD_ADDR;
    assign ld_count = fv && fc == FN_LD_COUNT;
    assign ld_dev = fv && fc == FN_LD_DEV;
    assign ld_tags = fv && fc == FN_LD_TAGS;
    assign rd_addr = fv && fc == FN_RD_ADDR;
    assign rd_count = fv && fc == FN_RD_COUNT;
    assign rd_stat = fv && fc == FN_RD_STATUS;
    assign rd_tags = fv && fc == FN_RD_TAGS;
    assign clr_en = fv && fc == FN_CLR_IRQ_EN;
    assign set_en = fv && fc == FN_SET_IRQ_EN;

    // ----------------------------------------
    // Address registers and chaining
    // ----------------------------------------
    logic [15:0] addr_reg [2];
    logic cur_sel_reg;
    logic chain_reg;
    logic [15:0] count_reg;
    logic [15:0] next_count_reg;
    logic seg_end;
    assign seg_end = BYTE_DONE_I && count_reg == 16'h0001;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            addr_reg[0] <= ZERO16;
            addr_reg[1] <= ZERO16;
            cur_sel_reg <= 1'b0;
        end
        else if (ld_addr)
        begin
            addr_reg[acc[LA_SEL_BIT]] <= acc;
            cur_sel_reg <= acc[LA_SEL_BIT];
        end
        else if (BYTE_DONE_I && count_reg != ZERO16)
        begin
            addr_reg[cur_sel_reg] <= addr_reg[cur_sel_reg] + 16'h0001;
            // Next segment continues from the other address register
            if (seg_end && chain_reg)
                cur_sel_reg <= ~cur_sel_reg;
        end
    end
    assign MEM_ADDR_O = addr_reg[cur_sel_reg];

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            chain_reg <= 1'b0;
        else if (ld_addr && acc[LA_CHAIN_BIT])
            chain_reg <= 1'b1;
        else if (seg_end && next_count_reg == ZERO16)
            chain_reg <= 1'b0;
    end

    // ----------------------------------------
    // Byte counter
    // ----------------------------------------
    logic prev_cnt_reg;
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            prev_cnt_reg <= 1'b0;
        else if (fv)
            prev_cnt_reg <= ld_count && !prev_cnt_reg;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            count_reg <= ZERO16;
            next_count_reg <= ZERO16;
        end
        // first to counter, second to next
        else if (ld_count && prev_cnt_reg)
            next_count_reg <= acc;
        else if (ld_count)
            count_reg <= acc;
        else if (seg_end && chain_reg)
        begin
            count_reg <= next_count_reg;
            next_count_reg <= ZERO16;
        end
        else if (BYTE_DONE_I && count_reg != ZERO16)
            count_reg <= count_reg - 16'h0001;
        // early end keeps the remaining count
    end

    // ----------------------------------------
    // Interrupt flags, set wins over clear
    // ----------------------------------------
    logic irq_en_reg, done_irq_reg, chain_irq_reg, last_seg;
    assign last_seg = seg_end && (!chain_reg || next_count_reg == ZERO16);

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            irq_en_reg <= 1'b0;
        else if (set_en)
            irq_en_reg <= 1'b1;
        else if (clr_en)
            irq_en_reg <= 1'b0;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            done_irq_reg <= 1'b0;
        else if (last_seg || CU_END_I)
            done_irq_reg <= 1'b1;
        else if (ld_count || ld_addr)
            done_irq_reg <= 1'b0;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            chain_irq_reg <= 1'b0;
        else if (seg_end && !last_seg)
            chain_irq_reg <= 1'b1;
        // Rearm by clearing enable; a fresh address load also clears it
        else if (clr_en || ld_addr)
            chain_irq_reg <= 1'b0;
    end
    assign FN.chan_irq = irq_en_reg && (done_irq_reg || chain_irq_reg);

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            XFER_END_O <= 1'b0;
        else
            XFER_END_O <= last_seg || CU_END_I;
    end

    // ----------------------------------------
    // Status register and staging
    // ----------------------------------------
    logic [15:0] status_reg, cnt_stage_reg, stat_stage_reg, tag_stage_reg;
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            status_reg <= ZERO16;
        else if (ld_dev)
            status_reg <= {acc[7:0], acc[15:8]};
        else if (STAT_CAP_I)
            status_reg <= {DEV_ADDR_I, STAT_BYTE_I};
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            cnt_stage_reg <= ZERO16;
        else if (ld_count)
            cnt_stage_reg <= acc;
        else if (rd_count)
            cnt_stage_reg <= count_reg;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            stat_stage_reg <= ZERO16;
        else if (rd_stat)
            stat_stage_reg <= status_reg;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            tag_stage_reg <= ZERO16;
        else if (ld_tags)
            tag_stage_reg <= acc;
        // sample input tags; top bits are status
        else if (rd_tags)
            tag_stage_reg <= {CHAN_BUSY_I, CHAN_DONE_I, chain_reg, chain_irq_reg, IN_TAGS_I};
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            OUT_TAGS_O <= ZERO16;
        else if (ld_tags)
            OUT_TAGS_O <= acc;
    end

    // ----------------------------------------
    // Answer path
    // ----------------------------------------
    // reads touch no busy or done flag; those stay with the channel
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            FN.rsp_valid <= 1'b0;
            FN.rsp_data <= ZERO16;
        end
        else
        begin
            FN.rsp_valid <= rd_addr || rd_count || rd_stat || rd_tags;
            // address read never stalls other logic
            if (rd_addr)
                FN.rsp_data <= {addr_reg[acc[LA_SEL_BIT]][15:2], chain_reg, acc[LA_SEL_BIT]};
            else if (rd_count)
                FN.rsp_data <= cnt_stage_reg;
            else if (rd_stat)
                FN.rsp_data <= stat_stage_reg;
            else if (rd_tags)
                FN.rsp_data <= tag_stage_reg;
        end
    end
endmodule // crb_dev
`default_nettype wire

// File: hw/crb_host.sv
// Host end: Wishbone slave that issues channel functions
`timescale 1ns/100ps
`default_nettype none
module crb_host
    import crb_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    crb_if.host FN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic IRQ_O
);
    typedef enum {S_IDLE, S_ISSUE, S_GAP} crb_state_t;
    crb_state_t state_reg;
    logic [3:0] code_reg;
    logic [15:0] acc_reg;
    logic twice_reg, rearm_reg, rsp_ok_reg;
    logic [15:0] rsp_reg;
    logic req, cmd_wr;
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign cmd_wr = req && WB_WE_I && WB_ADR_I == REG_CMD && WB_SEL_I == 4'hF && state_reg == S_IDLE;

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= ZERO32;
        end
        else
        begin
            WB_ACK_O <= req;
            case (WB_ADR_I)
                REG_RESP: WB_DAT_O <= {15'h0, rsp_ok_reg, rsp_reg};
                REG_STAT: WB_DAT_O <= {30'h0, IRQ_O, state_reg != S_IDLE};
                default: WB_DAT_O <= ZERO32;
            endcase
        end
    end
    assign IRQ_O = FN.chan_irq;

    // ----------------------------------------
    // Function sequencer
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            state_reg <= S_IDLE;
            code_reg <= 4'h0;
            acc_reg <= ZERO16;
            twice_reg <= 1'b0;
            rearm_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                S_IDLE:
                    if (cmd_wr)
                    begin
                        code_reg <= WB_DAT_I[CMD_REARM_BIT] ? FN_CLR_IRQ_EN : WB_DAT_I[CMD_CODE_LSB +: 4];
                        acc_reg <= WB_DAT_I[CMD_ACC_LSB +: 16];
                        twice_reg <= WB_DAT_I[CMD_TWICE_BIT];
                        rearm_reg <= WB_DAT_I[CMD_REARM_BIT];
                        state_reg <= S_ISSUE;
                    end
                S_ISSUE:
                    // one idle cycle after every function
                    state_reg <= S_GAP;
                S_GAP:
                    if (rearm_reg)
                    begin
                        rearm_reg <= 1'b0;
                        code_reg <= FN_SET_IRQ_EN;
                        state_reg <= S_ISSUE;
                    end
                    else if (twice_reg)
                    begin
                        twice_reg <= 1'b0;
                        state_reg <= S_ISSUE;
                    end
                    else
                        state_reg <= S_IDLE;
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end
    assign FN.fn_valid = state_reg == S_ISSUE;
    assign FN.fn_code = code_reg;
    assign FN.fn_acc = acc_reg;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            rsp_reg <= ZERO16;
            rsp_ok_reg <= 1'b0;
        end
        else if (FN.rsp_valid)
        begin
            rsp_reg <= FN.rsp_data;
            rsp_ok_reg <= 1'b1;
        end
        else if (cmd_wr)
            rsp_ok_reg <= 1'b0;
    end
endmodule // crb_host
`default_nettype wire

// File: tb/crb_chk.sv
// Assertion checker on the function link between host and device ends
`timescale 1ns/100ps
`default_nettype none
module crb_chk
    import crb_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic fn_valid,
    input wire logic [3:0] fn_code,
    input wire logic [15:0] fn_acc,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic chan_irq
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RST_I);
    logic [3:0] prev_code_reg;
    logic [15:0] last_acc_reg;
    logic chain_reg;
    logic rd_fn;
    assign rd_fn = fn_valid && fn_code >= FN_RD_ADDR && fn_code <= FN_RD_TAGS;
    // ----------------------------------------
    // Shadow of the last function taken
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            prev_code_reg <= 4'h0;
            last_acc_reg <= 16'h0000;
            chain_reg <= 1'b0;
        end
        else if (fn_valid)
        begin
            prev_code_reg <= fn_code;
            last_acc_reg <= fn_acc;
            if (fn_code == FN_LD_ADDR)
                chain_reg <= fn_acc[LA_CHAIN_BIT];
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_rsp_after_read: assert property (rd_fn |=> rsp_valid)
        else $error("read function got no answer");
    a_rsp_only_read: assert property (rsp_valid |-> $past(rd_fn))
        else $error("answer without a read function");
    a_rsp_one_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer strobe longer than one cycle");
    a_rsp_data_hold: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("answer data moved without a strobe");
    a_addr_sel_echo: assert property (fn_valid && fn_code == FN_RD_ADDR |=>
        rsp_data[RA_SEL_BIT] == last_acc_reg[LA_SEL_BIT]) else $error("address source bit wrong");
    a_chain_bit: assert property (fn_valid && fn_code == FN_RD_ADDR |=>
        rsp_data[RA_CHAIN_BIT] == chain_reg) else $error("chaining bit wrong");
    a_count_path: assert property (fn_valid && fn_code == FN_RD_COUNT && prev_code_reg == FN_LD_COUNT |=>
        rsp_data == $past(last_acc_reg)) else $error("loaded count not staged");
    a_tag_path: assert property (fn_valid && fn_code == FN_RD_TAGS && prev_code_reg == FN_LD_TAGS |=>
        rsp_data == $past(last_acc_reg)) else $error("loaded tags not staged");
    a_irq_clear: assert property (fn_valid && fn_code == FN_CLR_IRQ_EN |=> !chan_irq [*2])
        else $error("interrupt still up after enable cleared");
    c_read_answer: cover property (rd_fn ##1 rsp_valid);
    c_irq_seen: cover property (chan_irq);
    c_chain_read: cover property (fn_valid && fn_code == FN_RD_ADDR && chain_reg);
endmodule // crb_chk
`default_nettype wire

// File: tb/tb_top.sv
// Testbench: both ends joined, driven over Wishbone and the channel side
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import crb_pkg::*;
();
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [3:0] wsel = 4'hF;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic irq;
    logic byte_done = 1'b0;
    logic cu_end = 1'b0;
    logic stat_cap = 1'b0;
    logic [7:0] stat_byte = 8'h5C;
    logic [7:0] dev_addr = 8'hA7;
    logic [TAG_W-1:0] in_tags = 12'hABC;
    logic [15:0] out_tags;
    logic [15:0] mem_addr;
    logic xfer_end;
    logic [15:0] resp;
    logic [31:0] q;
    int miscompares = 0;
    int tests_run = 0;
    int ends = 0;
    int e0;
    crb_if fn_link();
    crb_dev crb_dev_inst(.CLK_SYS_I(clk_sys), .RST_I(rst), .FN(fn_link), .BYTE_DONE_I(byte_done),
        .CU_END_I(cu_end), .STAT_CAP_I(stat_cap), .STAT_BYTE_I(stat_byte), .DEV_ADDR_I(dev_addr),
        .IN_TAGS_I(in_tags), .CHAN_BUSY_I(1'b1), .CHAN_DONE_I(1'b0), .OUT_TAGS_O(out_tags),
        .MEM_ADDR_O(mem_addr), .XFER_END_O(xfer_end));
    crb_host crb_host_inst(.CLK_SYS_I(clk_sys), .RST_I(rst), .FN(fn_link), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .IRQ_O(irq));
    crb_chk crb_chk_inst(.CLK_SYS_I(clk_sys), .RST_I(rst), .fn_valid(fn_link.fn_valid),
        .fn_code(fn_link.fn_code), .fn_acc(fn_link.fn_acc), .rsp_valid(fn_link.rsp_valid),
        .rsp_data(fn_link.rsp_data), .chan_irq(fn_link.chan_irq));
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (xfer_end === 1'b1)
            ends++;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic final_report();
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One classic cycle; the request stands until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        if (ack !== 1'b1)
        begin
            miscompares++;
            final_report();
        end
    endtask
    // Issue a function, wait for the host to go idle, fetch the answer
    task automatic fn(input logic [3:0] c, input logic [15:0] acc, input logic [1:0] m);
        int n;
        wb(1'b1, REG_CMD, {acc, 10'h000, m, c});
        n = 0;
        do
        begin
            wb(1'b0, REG_STAT, ZERO32);
            n++;
        end
        while (q[0] !== 1'b0 && n < 20);
        if (q[0] !== 1'b0)
        begin
            miscompares++;
            final_report();
        end
        wb(1'b0, REG_RESP, ZERO32);
        resp = q[15:0];
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys);
        byte_done <= (k == 0);
        cu_end <= (k == 1);
        stat_cap <= (k == 2);
        @(posedge clk_sys);
        byte_done <= 1'b0;
        cu_end <= 1'b0;
        stat_cap <= 1'b0;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        wb(1'b0, REG_STAT, ZERO32);
        chk("stat_reset", ZERO32, q);
        wb(1'b0, 4'hC, ZERO32);
        chk("unmapped", ZERO32, q);
        // A command write without all byte lanes is acked and dropped
        wsel = 4'h3;
        wb(1'b1, REG_CMD, {16'h1111, 12'h000, FN_LD_TAGS});
        wsel = 4'hF;
        wb(1'b0, REG_STAT, ZERO32);
        chk("sel_refused", ZERO32, q);
        chk("tags_kept", ZERO32, out_tags);
        fn(FN_LD_TAGS, 16'h5A3C, 2'b00);
        chk("out_tags", 32'h0000_5A3C, out_tags);
        fn(FN_RD_TAGS, ZERO16, 2'b00);
        chk("tag_path", 32'h0000_5A3C, resp);
        fn(FN_RD_TAGS, ZERO16, 2'b01);
        chk("in_tags", 32'h0000_8ABC, resp);
        fn(FN_LD_DEV, 16'h1234, 2'b00);
        chk("rsp_none", ZERO32, q[16]);
        fn(FN_RD_STATUS, ZERO16, 2'b01);
        chk("dev_path", 32'h0000_3412, resp);
        chk("rsp_ok", 32'h0000_0001, q[16]);
        pulse(2);
        fn(FN_RD_STATUS, ZERO16, 2'b01);
        chk("status", 32'h0000_A75C, resp);
        fn(FN_SET_IRQ_EN, ZERO16, 2'b00);
        fn(FN_LD_ADDR, 16'h0100, 2'b00);
        fn(FN_LD_COUNT, 16'h0003, 2'b00);
        fn(FN_RD_COUNT, ZERO16, 2'b00);
        chk("count_path", 32'h0000_0003, resp);
        pulse(0);
        fn(FN_RD_COUNT, ZERO16, 2'b01);
        chk("count_dec", 32'h0000_0002, resp);
        chk("mem_addr", 32'h0000_0101, mem_addr);
        fn(FN_RD_ADDR, ZERO16, 2'b00);
        chk("rd_addr", 32'h0000_0100, resp);
        chk("irq_idle", ZERO32, irq);
        pulse(1);
        fn(FN_RD_COUNT, ZERO16, 2'b01);
        chk("count_kept", 32'h0000_0002, resp);
        chk("irq_cu_end", 32'h0000_0001, irq);
        fn(FN_LD_ADDR, 16'h0200, 2'b00);
        fn(FN_LD_COUNT, 16'h0002, 2'b00);
        e0 = ends;
        repeat (3) pulse(0);
        fn(FN_RD_COUNT, ZERO16, 2'b01);
        chk("count_zero", ZERO32, resp);
        chk("xfer_end", 32'h0000_0001, 32'(ends - e0));
        chk("irq_done", 32'h0000_0001, irq);
        fn(FN_LD_ADDR, 16'h0302, 2'b00);
        fn(FN_LD_COUNT, 16'h0001, 2'b00);
        fn(FN_LD_COUNT, 16'h0004, 2'b00);
        fn(FN_RD_ADDR, ZERO16, 2'b00);
        chk("chain_flag", 32'h0000_0302, resp);
        pulse(0);
        fn(FN_RD_COUNT, ZERO16, 2'b01);
        chk("reload", 32'h0000_0004, resp);
        fn(FN_RD_ADDR, 16'h0001, 2'b00);
        chk("next_sel", 32'h0000_0003, resp);
        chk("irq_chain", 32'h0000_0001, irq);
        fn(FN_CLR_IRQ_EN, ZERO16, 2'b10);
        chk("irq_rearm", ZERO32, irq);
        final_report();
    end
endmodule // tb_top
`default_nettype wire
